// file: rtl/usart_ext_consts.svh
// Constants for the serial mode extension block.
`ifndef USART_EXT_CONSTS_SVH
`define USART_EXT_CONSTS_SVH
`define LDM_OFF 2'h0
`define LDM_EXTERNAL 2'h1
`define LDM_INTERNAL 2'h2
`define OVS_NORMAL 5'h10
`define OVS_DOUBLE 5'h08
`define VOTE_NORMAL 5'h08
`define VOTE_DOUBLE 5'h04
`define ZERO_CNT 5'h00
`define ONE_CNT 5'h01
`define STOP_MASK 4'h0
`define BIT_TOP 3'h7
`define BIT_ZERO 3'h0
`endif

// file: rtl/usart_ext_pkg.sv
// Types shared by the serial mode extension block.
package usart_ext_pkg;
  typedef enum logic [1:0] {
    ldm_off,
    ldm_external,
    ldm_internal,
    ldm_reserved
  } line_driver_mode_t;
  typedef logic [15:0] baud_div_t;
  typedef logic [7:0] data_byte_t;
endpackage

// file: rtl/usart_ext_if.sv
// Baud tick bundle between the divider and the core.
`timescale 1ns/1ps
interface baud_link_if;
  logic tick;
  logic half_tick;
  logic restart;
  modport gen (output tick, output half_tick, input restart);
  modport use_side (input tick, input half_tick, output restart);
endinterface

// file: rtl/baud_tick_gen.sv
// Baud divider producing full and half period ticks.
`timescale 1ns/1ps
module baud_tick_gen
  import usart_ext_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Setting
  input wire usart_ext_pkg::baud_div_t div,
  // Ticks
  baud_link_if.gen bl
);
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic tick;
  logic half;
  logic next_tick;
  logic next_half;
  assign bl.tick = tick;
  assign bl.half_tick = half;
  always_comb begin
    next_cnt = cnt + 16'h0001;
    next_tick = 1'b0;
    next_half = (cnt == {1'b0, div[15:1]});
    if (bl.restart) begin
      next_cnt = 16'h0000;
      next_half = 1'b0;
    end else if (cnt >= div) begin
      next_cnt = 16'h0000;
      next_tick = 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt <= 16'h0000;
      tick <= 1'b0;
      half <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
      half <= next_half;
    end
  end
endmodule

// file: rtl/usart_mode_ext.sv
// Master SPI transmit path, line driver enable and start frame detect.
`timescale 1ns/1ps
`include "usart_ext_consts.svh"
module usart_mode_ext
  import usart_ext_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Configuration
  input wire logic tx_enable,
  input wire logic rx_enable,
  input wire logic spi_mode,
  input wire logic clock_phase_select,
  input wire logic bit_order_select,
  input wire logic double_speed_select,
  input wire usart_ext_pkg::line_driver_mode_t line_driver_mode,
  input wire logic [1:0] stop_bits,
  input wire usart_ext_pkg::baud_div_t baud_div,
  input wire logic start_frame_detect_enable,
  input wire logic standby_sleep,
  input wire logic start_int_enable,
  input wire logic rxc_int_enable,
  input wire logic other_wake,
  // Data write and read
  input wire logic data_write,
  input wire usart_ext_pkg::data_byte_t data_in,
  input wire logic start_flag_clear,
  input wire logic rx_read,
  // Pins
  input wire logic rxd,
  output logic txd,
  output logic txd_oe,
  output logic master_transfer_clock_pin,
  output logic transmit_drive_enable,
  // Status
  output logic buffer_empty,
  output logic transmit_complete,
  output logic receive_complete_flag,
  output usart_ext_pkg::data_byte_t rx_data,
  output logic error_flags_zero,
  output logic start_detected_flag,
  output logic clock_request,
  output logic wake_request
);
  import usart_ext_pkg::*;
  // ****************************************************
  // Baud ticks
  // ****************************************************
  baud_link_if bl();
  baud_tick_gen u_baud (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .div(baud_div),
    .bl(bl)
  );
  // ****************************************************
  // Transmit and shift path
  // ****************************************************
  typedef enum logic [2:0] {s_idle, s_guard, s_start, s_data, s_stop} tx_state_t;
  tx_state_t st, next_st;
  data_byte_t buf_d, next_buf_d, sh, next_sh, rsh, next_rsh;
  logic buf_v, next_buf_v;
  logic [2:0] bitn, next_bitn;
  logic [1:0] stopn, next_stopn;
  logic sck, next_sck, phase_b, next_phase_b;
  logic txd_n, oe_n, te_n, tc_n, rxc_n;
  data_byte_t rxd_n;
  logic miso;
  logic spi_bit_out;
  logic shift_active;
  assign spi_bit_out = bit_order_select ? sh[0] : sh[7];
  assign miso = rxd;
  assign shift_active = (st != s_idle);
  assign bl.restart = (st == s_idle) && !buf_v;
  always_comb begin
    next_st = st;
    next_buf_d = buf_d;
    next_buf_v = buf_v;
    next_sh = sh;
    next_rsh = rsh;
    next_bitn = bitn;
    next_stopn = stopn;
    next_sck = sck;
    next_phase_b = phase_b;
    tc_n = transmit_complete;
    rxc_n = receive_complete_flag && !rx_read;
    rxd_n = rx_data;
    // A write while the buffer is full is simply dropped; no collision flag exists.
    if (data_write && !buf_v && tx_enable) begin
      next_buf_v = 1'b1;
      next_buf_d = data_in;
      tc_n = 1'b0;
    end
    unique case (st)
      s_idle: begin
        if (buf_v && bl.tick) begin
          next_sh = buf_d;
          next_buf_v = 1'b0;
          next_bitn = `BIT_ZERO;
          next_phase_b = 1'b0;
          next_st = spi_mode ? s_data : s_guard;
        end
      end
      s_guard: if (bl.tick) next_st = s_start;
      s_start: if (bl.tick) next_st = s_data;
      s_data: begin
        if (spi_mode) begin
          // Half-period ticks toggle the transfer clock; the divisor alone sets speed.
          if (bl.half_tick || bl.tick) begin
            next_sck = !sck;
            next_phase_b = !phase_b;
            if (phase_b) begin
              next_rsh = bit_order_select ? {miso, rsh[7:1]} : {rsh[6:0], miso};
              next_sh = bit_order_select ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
              if (bitn == `BIT_TOP) begin
                next_sck = 1'b0;
                next_st = s_idle;
                tc_n = !next_buf_v;
                if (rx_enable) begin
                  rxc_n = 1'b1;
                  rxd_n = bit_order_select ? {miso, rsh[7:1]} : {rsh[6:0], miso};
                end
              end
              next_bitn = bitn + 3'h1;
            end
          end
        end else if (bl.tick) begin
          next_sh = {1'b0, sh[7:1]};
          next_bitn = bitn + 3'h1;
          if (bitn == `BIT_TOP) begin
            next_st = s_stop;
            next_stopn = stop_bits;
          end
        end
      end
      s_stop: begin
        if (bl.tick) begin
          next_stopn = stopn - 2'h1;
          if (stopn == 2'h1 || stopn == 2'h0) begin
            if (buf_v) begin
              next_sh = buf_d;
              next_buf_v = 1'b0;
              next_bitn = `BIT_ZERO;
              next_st = s_start;
            end else begin
              next_st = s_idle;
              tc_n = !next_buf_v;
            end
          end
        end
      end
      default: next_st = s_idle;
    endcase
    // Disabling receive is immediate and clears the receive complete flag; rx_data keeps its value.
    if (!rx_enable) rxc_n = 1'b0;
  end
  always_comb begin
    if (spi_mode && st == s_data) txd_n = (clock_phase_select && !phase_b) ? txd : spi_bit_out;
    else if (st == s_start) txd_n = 1'b0;
    else if (st == s_data) txd_n = sh[0];
    else txd_n = 1'b1;
    // Outside internal line driver mode the transmitter holds the pin while enabled or still busy with pending data.
    oe_n = tx_enable || shift_active || buf_v;
    if (line_driver_mode == ldm_internal) oe_n = shift_active && !spi_mode;
    te_n = (line_driver_mode == ldm_external) && shift_active && !spi_mode
      && (st != s_idle);
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st <= s_idle;
      buf_d <= 8'h00;
      buf_v <= 1'b0;
      sh <= 8'h00;
      rsh <= 8'h00;
      bitn <= `BIT_ZERO;
      stopn <= 2'h0;
      sck <= 1'b0;
      phase_b <= 1'b0;
      txd <= 1'b1;
      txd_oe <= 1'b0;
      transmit_drive_enable <= 1'b0;
      master_transfer_clock_pin <= 1'b0;
      transmit_complete <= 1'b0;
      receive_complete_flag <= 1'b0;
      rx_data <= 8'h00;
      error_flags_zero <= 1'b0;
      buffer_empty <= 1'b1;
    end else begin
      st <= next_st;
      buf_d <= next_buf_d;
      buf_v <= next_buf_v;
      sh <= next_sh;
      rsh <= next_rsh;
      bitn <= next_bitn;
      stopn <= next_stopn;
      sck <= next_sck;
      phase_b <= next_phase_b;
      txd <= txd_n;
      txd_oe <= oe_n;
      transmit_drive_enable <= te_n;
      master_transfer_clock_pin <= spi_mode ? next_sck : 1'b0;
      transmit_complete <= tc_n;
      receive_complete_flag <= rxc_n;
      rx_data <= rxd_n;
      error_flags_zero <= 1'b0;
      buffer_empty <= !next_buf_v;
    end
  end
  // ****************************************************
  // Start frame detection
  // ****************************************************
  typedef enum logic [1:0] {d_wait, d_check, d_hold} det_state_t;
  det_state_t ds, next_ds;
  logic [4:0] scnt, next_scnt;
  logic [1:0] votes, next_votes;
  logic rx_prev, armed, next_sdf, next_clk_req, next_wake;
  logic [4:0] vote_at;
  logic [4:0] ovs;
  assign ovs = double_speed_select ? `OVS_DOUBLE : `OVS_NORMAL;
  assign vote_at = {1'b0, ovs[4:1]};
  assign armed = start_frame_detect_enable && standby_sleep && !spi_mode;
  always_comb begin
    next_ds = ds;
    next_scnt = scnt;
    next_votes = votes;
    next_clk_req = clock_request;
    next_wake = wake_request;
    // A new start beats a clear in the same cycle.
    next_sdf = start_detected_flag && !start_flag_clear;
    unique case (ds)
      d_wait: begin
        if (armed && rx_prev && !rxd) begin
          next_ds = d_check;
          next_scnt = `ONE_CNT;
          next_votes = 2'h0;
          next_clk_req = 1'b1;
        end
      end
      d_check: begin
        next_scnt = scnt + `ONE_CNT;
        if (scnt >= vote_at && scnt <= vote_at + 5'h02 && !rxd) next_votes = votes + 2'h1;
        if (scnt == vote_at + 5'h02) begin
          if (votes + {1'b0, !rxd} >= 2'h2) begin
            next_ds = d_hold;
            next_sdf = 1'b1;
            next_wake = start_int_enable;
          end else if (!other_wake) begin
            next_ds = d_wait;
            next_clk_req = 1'b0;
          end else next_ds = d_hold;
        end
      end
      d_hold: begin
        if (receive_complete_flag && rxc_int_enable) next_wake = 1'b1;
        if (!standby_sleep || !start_frame_detect_enable) begin
          next_ds = d_wait;
          next_clk_req = 1'b0;
          next_wake = 1'b0;
        end
      end
      default: next_ds = d_wait;
    endcase
    if (!armed && ds == d_wait) next_clk_req = 1'b0;
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ds <= d_wait;
      scnt <= `ZERO_CNT;
      votes <= 2'h0;
      rx_prev <= 1'b1;
      start_detected_flag <= 1'b0;
      clock_request <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      ds <= next_ds;
      scnt <= next_scnt;
      votes <= next_votes;
      rx_prev <= rxd;
      start_detected_flag <= next_sdf;
      clock_request <= next_clk_req;
      wake_request <= next_wake;
    end
  end
  // ****************************************************
  // Checks
  // ****************************************************
  sequence guard_then_start;
    (st == s_guard) ##1 (st == s_guard || st == s_start);
  endsequence
  a_te_guard_lead: assert property (@(posedge mclk) disable iff (sys_rst)
    guard_then_start |-> ##1 (transmit_drive_enable || line_driver_mode != ldm_external))
    else $error("drive enable not high in guard");
  a_te_through_stop: assert property (@(posedge mclk) disable iff (sys_rst)
    (st == s_stop && line_driver_mode == ldm_external) |=> transmit_drive_enable)
    else $error("drive enable dropped in stop");
  a_te_drop_idle: assert property (@(posedge mclk) disable iff (sys_rst)
    (st == s_idle && $past(st) == s_idle) |=> !transmit_drive_enable)
    else $error("drive enable high when idle");
  a_err_zero: assert property (@(posedge mclk) disable iff (sys_rst)
    ##1 !error_flags_zero) else $error("error flags not zero");
  a_sck_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
    (!spi_mode && $past(!spi_mode)) |-> !master_transfer_clock_pin)
    else $error("transfer clock moves outside spi mode");
  a_sfd_disarm: assert property (@(posedge mclk) disable iff (sys_rst)
    (!standby_sleep && ds == d_wait) |=> !clock_request)
    else $error("clock request outside standby");
  a_sfd_flag: assert property (@(posedge mclk) disable iff (sys_rst)
    (ds == d_check && next_ds == d_hold && !other_wake) |=> start_detected_flag)
    else $error("start flag not set");
  a_load_ready: assert property (@(posedge mclk) disable iff (sys_rst)
    (st == s_data && next_st == s_data) |=> $stable(buf_d) || !$past(buf_v))
    else $error("buffer disturbed while shifting");
endmodule

// file: bench/spi_slave_model.sv
// Behavioural SPI slave standing on the far side of the master transfer pins.
`timescale 1ns/1ps
module spi_slave_model (
  // Bus pins
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  // Bench control
  input wire logic arm,
  input wire logic phase,
  input wire logic [7:0] resp,
  output logic [7:0] got,
  output int edges
);
  // ****************************************
  // Shifting
  // ****************************************
  initial begin
    edges = 0;
    got = 8'h00;
    miso = 1'b1;
  end

  // Edges are counted, not levels, so the idle polarity of the clock does not matter.
  always @(posedge arm) begin
    edges = 0;
    miso = resp[7];
  end

  always @(sck) begin
    edges++;
    if (edges[0] ^ phase) begin
      got = {got[6:0], mosi};
    end else if (edges < 16) begin
      miso = resp[7 - ((edges - phase) / 2)];
    end else begin
      // A released line does not keep its last value.
      miso = ~miso;
    end
  end
endmodule

// file: bench/usart_mode_ext_bench.sv
// Self-checking bench for the serial mode extension block.
`timescale 1ns/1ps
module usart_mode_ext_bench;
  import usart_ext_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  localparam int BL = 4;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic tx_enable = 1'b1;
  logic rx_enable = 1'b0;
  logic spi_mode = 1'b0;
  logic clock_phase_select = 1'b0;
  logic bit_order_select = 1'b0;
  logic double_speed_select = 1'b0;
  line_driver_mode_t line_driver_mode = ldm_off;
  logic [1:0] stop_bits = 2'h1;
  baud_div_t baud_div = 16'h0003;
  logic start_frame_detect_enable = 1'b0;
  logic standby_sleep = 1'b0;
  logic start_int_enable = 1'b0;
  logic rxc_int_enable = 1'b0;
  logic other_wake = 1'b0;
  logic data_write = 1'b0;
  data_byte_t data_in = 8'h00;
  logic start_flag_clear = 1'b0;
  logic rx_read = 1'b0;
  logic line_rxd = 1'b1;
  logic arm = 1'b0;
  data_byte_t resp = 8'h00;
  logic rxd, txd, txd_oe, master_transfer_clock_pin, transmit_drive_enable, miso;
  logic buffer_empty, transmit_complete, receive_complete_flag, error_flags_zero;
  logic start_detected_flag, clock_request, wake_request;
  data_byte_t rx_data;
  logic [7:0] slave_got;
  int slave_edges;
  int miscompares = 0;
  int cmp_count = 0;

  always #4 mclk = ~mclk;
  assign rxd = spi_mode ? miso : line_rxd;

  usart_mode_ext DUT (.mclk, .sys_rst, .tx_enable, .rx_enable, .spi_mode, .clock_phase_select,
    .bit_order_select, .double_speed_select, .line_driver_mode, .stop_bits, .baud_div,
    .start_frame_detect_enable, .standby_sleep, .start_int_enable, .rxc_int_enable,
    .other_wake, .data_write, .data_in, .start_flag_clear, .rx_read, .rxd, .txd, .txd_oe,
    .master_transfer_clock_pin, .transmit_drive_enable, .buffer_empty, .transmit_complete,
    .receive_complete_flag, .rx_data, .error_flags_zero, .start_detected_flag,
    .clock_request, .wake_request);

  spi_slave_model slave (.sck(master_transfer_clock_pin), .mosi(txd), .miso(miso),
    .arm(arm), .phase(clock_phase_select), .resp(resp), .got(slave_got),
    .edges(slave_edges));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_lvl(input string what, ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge mclk);
      n++;
    end
    chk(what, v, s);
  endtask

  task automatic put(input data_byte_t b);
    data_in <= b;
    data_write <= 1'b1;
    @(posedge mclk);
    data_write <= 1'b0;
  endtask

  function automatic logic drv();
    return (line_driver_mode == ldm_internal) ? txd_oe : transmit_drive_enable;
  endfunction

  function automatic data_byte_t rev(input data_byte_t v);
    data_byte_t r;
    for (int i = 0; i < 8; i++) r[i] = v[7 - i];
    return r;
  endfunction

  // Samples mid-bit; the first loop also counts the guard time before the start bit.
  task automatic get_frame(input data_byte_t exp, input logic lead, input logic last);
    data_byte_t b;
    int n;
    int t;
    n = 0;
    t = 0;
    while (txd !== 1'b0 && t < 400) begin
      @(posedge mclk);
      t++;
      if (drv() === 1'b1) n++;
    end
    if (lead) chk("guard length", 1'b1, n >= BL - 1 && n <= BL + 1);
    repeat (BL / 2) @(posedge mclk);
    chk("start bit", 1'b0, txd);
    chk("enable at start", 1'b1, drv());
    for (int i = 0; i < 8; i++) begin
      repeat (BL) @(posedge mclk);
      b[i] = txd;
      chk("enable in frame", 1'b1, drv());
    end
    chk("frame data", exp, b);
    for (int i = 0; i < stop_bits; i++) begin
      repeat (BL) @(posedge mclk);
      chk("stop bit", 1'b1, txd);
      chk("enable in stop", 1'b1, drv());
    end
    if (last) begin
      repeat (2 * BL) @(posedge mclk);
      chk("enable after", 1'b0, drv());
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    repeat (3) @(posedge mclk);
    chk("reset txd", 1'b1, txd);
    chk("reset enable", 1'b0, transmit_drive_enable);
    chk("reset sck", 1'b0, master_transfer_clock_pin);
    $display("test reset done");
  endtask

  task automatic t_line_driver_mode(input line_driver_mode_t m, input logic [1:0] sb, input logic two);
    line_driver_mode <= m;
    stop_bits <= sb;
    repeat (2) @(posedge mclk);
    chk("idle enable", 1'b0, drv());
    fork
      begin
        get_frame(8'hA5, m == ldm_external && !two, !two);
        if (two) get_frame(8'h3C, 1'b0, 1'b1);
      end
      if (two) begin
        put(8'hA5);
        @(posedge mclk);
        wait_lvl("buffer empty", buffer_empty, 1'b1, 40);
        put(8'h3C);
        #1;
        chk("buffer full", 1'b0, buffer_empty);
        @(posedge mclk);
        // Refused while full; a third frame would keep the enable up.
        put(8'hFF);
      end else put(8'hA5);
    join
    chk("tx complete", 1'b1, transmit_complete);
    $display("test line driver done");
  endtask

  task automatic t_spi(input logic ph, input logic ord, input data_byte_t tx, input data_byte_t rs);
    spi_mode <= 1'b1;
    clock_phase_select <= ph;
    bit_order_select <= ord;
    rx_enable <= 1'b1;
    resp <= rs;
    repeat (4) @(posedge mclk);
    arm <= 1'b1;
    @(posedge mclk);
    arm <= 1'b0;
    put(tx);
    wait_lvl("rx complete", receive_complete_flag, 1'b1, 40 * BL);
    repeat (2 * BL) @(posedge mclk);
    chk("mosi byte", ord ? rev(tx) : tx, slave_got);
    chk("miso byte", ord ? rev(rs) : rs, rx_data);
    chk("clock edges", 8'h10, slave_edges[7:0]);
    chk("sck idle", 1'b0, master_transfer_clock_pin);
    chk("error flags", 1'b0, error_flags_zero);
    chk("spi tx complete", 1'b1, transmit_complete);
    rx_read <= 1'b1;
    @(posedge mclk);
    rx_read <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("rx cleared", 1'b0, receive_complete_flag);
    $display("test spi done");
  endtask

  task automatic t_sfd();
    spi_mode <= 1'b0;
    start_int_enable <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      start_frame_detect_enable <= (i == 0);
      standby_sleep <= (i != 0);
      line_rxd <= 1'b0;
      repeat (24) @(posedge mclk);
      line_rxd <= 1'b1;
      repeat (4) @(posedge mclk);
      chk("blocked start", 1'b0, start_detected_flag);
    end
    start_frame_detect_enable <= 1'b1;
    line_rxd <= 1'b0;
    wait_lvl("clock request", clock_request, 1'b1, 4);
    line_rxd <= 1'b1;
    repeat (40) @(posedge mclk);
    chk("false start clock", 1'b0, clock_request);
    chk("false start flag", 1'b0, start_detected_flag);
    // A start bit too short for the normal speed vote must pass the double speed vote.
    double_speed_select <= 1'b1;
    line_rxd <= 1'b0;
    repeat (8) @(posedge mclk);
    line_rxd <= 1'b1;
    wait_lvl("start flag", start_detected_flag, 1'b1, 30);
    wait_lvl("wake", wake_request, 1'b1, 8);
    repeat (200) @(posedge mclk);
    start_flag_clear <= 1'b1;
    @(posedge mclk);
    start_flag_clear <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("flag cleared", 1'b0, start_detected_flag);
    $display("test start detect done");
  endtask

  // ****************************************
  // Run
  // ****************************************
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    t_reset();
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    t_line_driver_mode(ldm_external, 2'h1, 1'b0);
    t_line_driver_mode(ldm_external, 2'h2, 1'b1);
    t_line_driver_mode(ldm_internal, 2'h1, 1'b0);
    t_spi(1'b0, 1'b0, 8'hA5, 8'h3C);
    t_spi(1'b1, 1'b0, 8'h81, 8'h4E);
    t_spi(1'b0, 1'b1, 8'h17, 8'hE2);
    t_spi(1'b1, 1'b1, 8'h6C, 8'h93);
    t_sfd();
    wrap_up();
  end

  // The whole sequence needs about a thousand cycles; this leaves ample margin.
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    $display("[ERR] run time expected done seen timeout");
    wrap_up();
  end
endmodule
